// ==== hdl/eepc_host.sv ====
// Host-side controller that drives a byte-wide parallel EEPROM through its pins
`include "eepc_cfg.svh"
// What this block does
// - Host waits full 5 ms before next access unless polling shows completion.
// - Successive page byte loads start 0.15 us to 100 us apart.
// - Each byte load follows a proper write-enable controlled write sequence.
// - Between loads all three strobes stay high and the data pins are released.
// - Polling reads start only once the load window has closed, never between loads.
// - Every polling access runs as an ordinary read cycle.
module eepc_host #(
    parameter logic [19:0] BLC_MAX_CYC = 20'(`EEPC_BLC_MAX_CYC),
    parameter logic [19:0] WC_CYC = 20'(`EEPC_WC_CYC)
) (
    input wire logic clk, // System clock, 125 MHz
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic req_valid, // Request offered
    output logic req_ready, // Request taken this cycle
    input wire eepc_pkg::eepc_req_t req, // Request contents
    input wire logic poll_en, // Poll for end of write
    output logic rd_valid, // Read data pulse
    output logic [`EEPC_DATA_W-1:0] rd_data, // Read data
    output logic busy, // Controller not idle
    output eepc_pkg::eepc_pins_t pins, // Memory pins out
    input wire logic [`EEPC_DATA_W-1:0] dq_i // Memory data pins in
);
    // ------------------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------------------
    localparam logic [19:0] RD_END = 20'(`EEPC_RD_CYC + `EEPC_SYNC_STAGES - 1);
    localparam logic [19:0] WP_END = 20'(`EEPC_WP_CYC - 1);
    localparam logic [19:0] AH_END = 20'(`EEPC_WP_CYC + `EEPC_AH_CYC - 1);
    localparam logic [19:0] REC_END = 20'(`EEPC_REC_CYC - 1);
    localparam logic [19:0] BLC_LO = 20'(`EEPC_BLC_MIN_CYC - 2);
    localparam logic [19:0] BLC_HI = BLC_MAX_CYC - 20'h0002;

    eepc_pkg::eepc_regs_t r_reg;
    eepc_pkg::eepc_regs_t r_next;
    logic [`EEPC_DATA_W-1:0] dq_s;
    logic poll_hit;

    eepc_sync #(
        .W(`EEPC_DATA_W)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(dq_i),
        .q(dq_s)
    );

    // ------------------------------------------------------------------------
    // Start of one byte load
    // ------------------------------------------------------------------------
    function automatic eepc_pkg::eepc_regs_t load_byte(
        input eepc_pkg::eepc_regs_t s,
        input eepc_pkg::eepc_req_t q
    );
        eepc_pkg::eepc_regs_t o;
        o = s;
        o.st = eepc_pkg::ST_WSET;
        o.pins.addr = q.addr;
        o.pins.ce_n = 1'b0;
        o.pins.oe_n = 1'b1;
        o.pins.dq_o = q.data;
        o.pins.dq_oe = 1'b1;
        o.last = q.data;
        o.more = q.more;
        return o;
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        r_next = r_reg;
        r_next.rvalid = 1'b0;
        req_ready = 1'b0;
        poll_hit = 1'b0;
        case (r_reg.st)
            eepc_pkg::ST_IDLE:
            begin
                req_ready = 1'b1;
                if (req_valid && req.write)
                begin
                    r_next = load_byte(r_reg, req);
                end
                else if (req_valid)
                begin
                    r_next.st = eepc_pkg::ST_READ;
                    r_next.cnt = 20'h0_0000;
                    r_next.pins.addr = req.addr;
                    r_next.pins.ce_n = 1'b0;
                    r_next.pins.oe_n = 1'b0;
                end
            end
            eepc_pkg::ST_WSET:
            begin
                r_next.st = eepc_pkg::ST_WPUL;
                r_next.cnt = 20'h0_0000;
                r_next.pins.we_n = 1'b0;
            end
            eepc_pkg::ST_WPUL:
            begin
                r_next.cnt = r_reg.cnt + 20'h0_0001;
                if (r_reg.cnt == WP_END)
                begin
                    r_next.st = eepc_pkg::ST_WHLD;
                    r_next.pins.we_n = 1'b1;
                end
            end
            eepc_pkg::ST_WHLD:
            begin
                r_next.cnt = r_reg.cnt + 20'h0_0001;
                if (r_reg.cnt == AH_END)
                begin
                    r_next.st = eepc_pkg::ST_GAP;
                    r_next.pins.ce_n = 1'b1;
                    r_next.pins.dq_oe = 1'b0;
                end
            end
            eepc_pkg::ST_GAP:
            begin
                // Counter runs from the last write-enable fall
                r_next.cnt = r_reg.cnt + 20'h0_0001;
                req_ready = r_reg.more && r_reg.cnt >= BLC_LO && r_reg.cnt <= BLC_HI;
                if (req_ready && req_valid && req.write)
                begin
                    r_next = load_byte(r_reg, req);
                end
                else if (r_reg.cnt >= BLC_MAX_CYC)
                begin
                    // Load window has closed; internal programming runs now
                    r_next.st = eepc_pkg::ST_PROG;
                    r_next.wtmr = 20'h0_0000;
                    r_next.cnt = 20'h0_0000;
                end
            end
            eepc_pkg::ST_PROG:
            begin
                r_next.wtmr = r_reg.wtmr + 20'h0_0001;
                r_next.cnt = r_reg.cnt + 20'h0_0001;
                if (r_reg.wtmr >= WC_CYC - 20'h0_0001)
                begin
                    r_next.st = eepc_pkg::ST_IDLE;
                end
                else if (poll_en && r_reg.cnt >= REC_END)
                begin
                    r_next.st = eepc_pkg::ST_POLL;
                    r_next.cnt = 20'h0_0000;
                    r_next.pins.addr = r_reg.pins.addr;
                    r_next.pins.ce_n = 1'b0;
                    r_next.pins.oe_n = 1'b0;
                end
            end
            eepc_pkg::ST_POLL:
            begin
                r_next.wtmr = r_reg.wtmr + 20'h0_0001;
                r_next.cnt = r_reg.cnt + 20'h0_0001;
                if (r_reg.cnt == RD_END)
                begin
                    r_next.pins.ce_n = 1'b1;
                    r_next.pins.oe_n = 1'b1;
                    r_next.cnt = 20'h0_0000;
                    // True data bit 7 returns once programming is over
                    poll_hit = dq_s[`EEPC_DATA_W-1] == r_reg.last[`EEPC_DATA_W-1];
                    r_next.st = poll_hit ? eepc_pkg::ST_RREC : eepc_pkg::ST_PROG;
                end
            end
            eepc_pkg::ST_READ:
            begin
                r_next.cnt = r_reg.cnt + 20'h0_0001;
                if (r_reg.cnt == RD_END)
                begin
                    r_next.st = eepc_pkg::ST_RREC;
                    r_next.cnt = 20'h0_0000;
                    r_next.rdata = dq_s;
                    r_next.rvalid = 1'b1;
                    r_next.pins.ce_n = 1'b1;
                    r_next.pins.oe_n = 1'b1;
                end
            end
            eepc_pkg::ST_RREC:
            begin
                r_next.cnt = r_reg.cnt + 20'h0_0001;
                if (r_reg.cnt >= REC_END)
                begin
                    r_next.st = eepc_pkg::ST_IDLE;
                end
            end
            default:
            begin
                r_next.st = eepc_pkg::ST_IDLE;
                r_next.pins.ce_n = `EEPC_STROBE_RST;
                r_next.pins.oe_n = `EEPC_STROBE_RST;
                r_next.pins.we_n = `EEPC_STROBE_RST;
                r_next.pins.dq_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            r_reg <= '0;
            r_reg.st <= eepc_pkg::ST_IDLE;
            r_reg.pins.ce_n <= `EEPC_STROBE_RST;
            r_reg.pins.oe_n <= `EEPC_STROBE_RST;
            r_reg.pins.we_n <= `EEPC_STROBE_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign pins = r_reg.pins;
    assign rd_valid = r_reg.rvalid;
    assign rd_data = r_reg.rdata;
    assign busy = r_reg.st != eepc_pkg::ST_IDLE;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    localparam int RD_LAT = `EEPC_RD_CYC + `EEPC_SYNC_STAGES + 1;
    logic [19:0] fall_gap;
    logic seen_fall;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            fall_gap <= 20'h0_0000;
            seen_fall <= 1'b0;
        end
        else if ($fell(pins.we_n))
        begin
            fall_gap <= 20'h0_0001;
            seen_fall <= 1'b1;
        end
        else if (fall_gap != 20'hF_FFFE)
        begin
            fall_gap <= fall_gap + 20'h0_0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_full_wait: assert property (r_reg.st == eepc_pkg::ST_PROG && r_next.st == eepc_pkg::ST_IDLE
        |-> r_reg.wtmr >= WC_CYC - 20'h0_0001)
        else $error("programming wait ended early");
    a_poll_early: assert property (r_reg.st == eepc_pkg::ST_RREC && $past(r_reg.st) == eepc_pkg::ST_POLL
        |-> $past(dq_s[`EEPC_DATA_W-1]) == r_reg.last[`EEPC_DATA_W-1])
        else $error("left programming wait without matching poll");
    a_load_min: assert property ($fell(pins.we_n) && seen_fall && $past(r_reg.st) != eepc_pkg::ST_IDLE
        |-> $past(fall_gap) + 20'h0_0001 >= 20'(`EEPC_BLC_MIN_CYC))
        else $error("byte loads too close together");
    a_load_max: assert property ($fell(pins.we_n) && $past(r_reg.st) == eepc_pkg::ST_WSET
        && $past(r_reg.st, 2) == eepc_pkg::ST_GAP
        |-> $past(fall_gap) + 20'h0_0001 <= BLC_MAX_CYC)
        else $error("byte load too late for page");
    a_we_pulse: assert property ($fell(pins.we_n) |-> !pins.we_n[*7] ##1 pins.we_n)
        else $error("write pulse width wrong");
    a_we_qual: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n && pins.dq_oe)
        else $error("write pulse without select, data or with output enable");
    a_addr_hold: assert property ($rose(pins.we_n) |-> $stable(pins.addr)[*7] ##0 !pins.ce_n)
        else $error("address or select not held after write");
    a_gap_quiet: assert property (r_reg.st == eepc_pkg::ST_GAP
        |-> pins.ce_n && pins.we_n && pins.oe_n && !pins.dq_oe)
        else $error("strobes not idle between loads");
    a_poll_read: assert property ($fell(pins.oe_n) |-> !pins.ce_n && pins.we_n && !pins.dq_oe
        ##0 (!pins.oe_n && !pins.dq_oe)[*8])
        else $error("polling access is not a read");
    a_read_time: assert property (req_valid && req_ready && !req.write && !busy
        |-> ##[1:RD_LAT] rd_valid)
        else $error("read data late");
    a_no_fight: assert property (!pins.oe_n |-> !pins.dq_oe)
        else $error("host drives data during read");

    c_read: cover property (req_valid && req_ready && !req.write ##[1:RD_LAT] rd_valid);
    c_page: cover property (r_reg.st == eepc_pkg::ST_GAP && req_ready && req_valid && req.write);
    c_poll_done: cover property (r_reg.st == eepc_pkg::ST_POLL && poll_hit);
    c_full_wait: cover property (r_reg.st == eepc_pkg::ST_PROG && r_next.st == eepc_pkg::ST_IDLE);
endmodule // eepc_host

// ==== hdl/eepc_cfg.svh ====
// Timing counts, widths and reset values for the parallel EEPROM host controller
`ifndef EEPC_CFG_SVH
`define EEPC_CFG_SVH

// ----------------------------------------------------------------------------
// Bus widths and clock
// ----------------------------------------------------------------------------
`define EEPC_ADDR_W 13
`define EEPC_DATA_W 8
`define EEPC_CLK_NS 8
`define EEPC_SYNC_STAGES 2

// ----------------------------------------------------------------------------
// Times in ns, as the memory needs them
// ----------------------------------------------------------------------------
`define EEPC_T_RD_NS 120
`define EEPC_T_WP_NS 50
`define EEPC_T_AH_NS 50
`define EEPC_T_REC_NS 50
`define EEPC_T_BLC_MIN_NS 150
`define EEPC_T_BLC_MAX_NS 100000
`define EEPC_T_WC_NS 5000000

// ----------------------------------------------------------------------------
// Cycle counts: least times round up, longest times round down
// ----------------------------------------------------------------------------
`define EEPC_CYC_UP(ns) (((ns) + `EEPC_CLK_NS - 1) / `EEPC_CLK_NS)
`define EEPC_CYC_DN(ns) ((ns) / `EEPC_CLK_NS)
`define EEPC_RD_CYC `EEPC_CYC_UP(`EEPC_T_RD_NS)
`define EEPC_WP_CYC `EEPC_CYC_UP(`EEPC_T_WP_NS)
`define EEPC_AH_CYC `EEPC_CYC_UP(`EEPC_T_AH_NS)
`define EEPC_REC_CYC `EEPC_CYC_UP(`EEPC_T_REC_NS)
`define EEPC_BLC_MIN_CYC `EEPC_CYC_UP(`EEPC_T_BLC_MIN_NS)
`define EEPC_BLC_MAX_CYC `EEPC_CYC_DN(`EEPC_T_BLC_MAX_NS)
`define EEPC_WC_CYC `EEPC_CYC_UP(`EEPC_T_WC_NS)

// ----------------------------------------------------------------------------
// Reset values of the strobes (inactive high)
// ----------------------------------------------------------------------------
`define EEPC_STROBE_RST 1'b1

`endif

// ==== hdl/eepc_pkg.sv ====
// Types shared by the parallel EEPROM host controller
`include "eepc_cfg.svh"

package eepc_pkg;

    // ------------------------------------------------------------------------
    // Controller states, Gray along the write path
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_WSET = 4'h1,
        ST_WPUL = 4'h3,
        ST_WHLD = 4'h2,
        ST_GAP = 4'h6,
        ST_PROG = 4'h7,
        ST_POLL = 4'h5,
        ST_READ = 4'h8,
        ST_RREC = 4'h9
    } eepc_st_t;

    // ------------------------------------------------------------------------
    // Memory pins driven by the host
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`EEPC_ADDR_W-1:0] addr;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [`EEPC_DATA_W-1:0] dq_o;
        logic dq_oe;
    } eepc_pins_t;

    // ------------------------------------------------------------------------
    // User request
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic more;
        logic [`EEPC_ADDR_W-1:0] addr;
        logic [`EEPC_DATA_W-1:0] data;
    } eepc_req_t;

    // ------------------------------------------------------------------------
    // Whole controller state
    // ------------------------------------------------------------------------
    typedef struct packed {
        eepc_st_t st;
        logic [19:0] cnt;
        logic [19:0] wtmr;
        logic [`EEPC_DATA_W-1:0] last;
        logic [`EEPC_DATA_W-1:0] rdata;
        logic rvalid;
        logic more;
        eepc_pins_t pins;
    } eepc_regs_t;

endpackage

// ==== hdl/eepc_sync.sv ====
// Two-stage synchroniser for the data pins read back from the memory
module eepc_sync #(
    parameter int W = 8
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // eepc_sync

// ==== tb/eepc_mem_model.sv ====
// Behavioural byte-wide EEPROM that answers the host controller's pins
`include "eepc_cfg.svh"

module eepc_mem_model (
    input wire eepc_pkg::eepc_pins_t pins, // Strobes, address and data from the host
    input wire logic slow, // Long internal programming when high
    output logic [7:0] dq, // Data pins as the host sees them
    output logic [7:0] viol // Count of host protocol breaches: timing, loads while programming, and data pin fights
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam realtime BLC_NS = 330.0;
    logic [7:0] mem [0:8191];
    logic [7:0] rd;
    logic [7:0] rd_dly;
    logic drv;
    logic page_open;
    logic prog;
    logic b7;
    realtime t_load;
    realtime t_wfall;
    realtime t_end;
    logic [12:0] qa[$];
    logic [7:0] qd[$];

    initial
    begin
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'(i) ^ 8'h5A;
        viol = 8'h00;
        page_open = 1'b0;
        prog = 1'b0;
        b7 = 1'b0;
        t_load = 0.0;
        t_wfall = 0.0;
        t_end = 0.0;
    end

    // Array drives only on a selected read; an OE strobe with CE high leaves it alone
    assign drv = !pins.ce_n && !pins.oe_n && pins.we_n;
    // While a write is open or programming, reads return the complement of bit 7
    assign rd = (page_open || prog) ? {~b7, pins.addr[6:0]} : mem[pins.addr];
    // Released pins show no stale byte
    assign #100 rd_dly = drv ? rd : ~rd;
    assign dq = pins.dq_oe ? pins.dq_o : rd_dly;

    always @(pins)
        if (drv && pins.dq_oe) viol = viol + 8'h01;

    task automatic load(input logic [12:0] a, input logic [7:0] d);
        if (prog) viol = viol + 8'h01;
        if (page_open && ($realtime - t_load) < 150.0) viol = viol + 8'h01;
        qa.push_back(a);
        qd.push_back(d);
        b7 = d[7];
        page_open = 1'b1;
        t_load = $realtime;
    endtask

    always @(negedge pins.we_n) t_wfall = $realtime;

    // Write-enable controlled load; OE low or CE high inhibits it
    always @(posedge pins.we_n)
    begin
        if (!pins.ce_n && pins.oe_n)
        begin
            if (($realtime - t_wfall) < 50.0) viol = viol + 8'h01;
            load(pins.addr, pins.dq_o);
        end
    end

    // Chip-select controlled load
    always @(posedge pins.ce_n)
        if (!pins.we_n && pins.oe_n) load(pins.addr, pins.dq_o);

    // Page window closes, then self-timed programming
    always
    begin
        #1;
        if (page_open && ($realtime - t_load) > BLC_NS)
        begin
            page_open = 1'b0;
            prog = 1'b1;
            t_end = $realtime + (slow ? 1000.0 : 400.0);
        end
        if (prog && $realtime >= t_end)
        begin
            while (qa.size() > 0)
                mem[qa.pop_front()] = qd.pop_front();
            prog = 1'b0;
        end
    end
endmodule // eepc_mem_model

// ==== tb/eepc_host_tb.sv ====
// Self-checking bench for the parallel EEPROM host controller
`include "eepc_cfg.svh"

module eepc_host_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int BLC = 40;
    localparam int WC = 200;
    logic clk;
    logic sys_rst;
    logic req_valid;
    logic req_ready;
    eepc_pkg::eepc_req_t req;
    logic poll_en;
    logic slow;
    logic rd_valid;
    logic [7:0] rd_data;
    logic busy;
    eepc_pkg::eepc_pins_t pins;
    logic [7:0] dq_i;
    logic [7:0] viol;
    int n_errors;
    int check_count;

    eepc_host #(
        .BLC_MAX_CYC(20'(BLC)),
        .WC_CYC(20'(WC))
    ) u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .req_valid(req_valid),
        .req_ready(req_ready),
        .req(req),
        .poll_en(poll_en),
        .rd_valid(rd_valid),
        .rd_data(rd_data),
        .busy(busy),
        .pins(pins),
        .dq_i(dq_i)
    );

    eepc_mem_model u_mem (
        .pins(pins),
        .slow(slow),
        .dq(dq_i),
        .viol(viol)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic fail_msg(input string msg);
        n_errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic check_val(input logic [25:0] got, input logic [25:0] exp, input string msg);
        check_count++;
        if (got !== exp) fail_msg(msg);
    endtask

    task automatic check_range(input int got, input int lo, input int hi, input string msg);
        check_count++;
        if (got < lo || got > hi) fail_msg($sformatf("%s %0d", msg, got));
    endtask

    task automatic report_and_stop();
        $display("errors %0d, checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic set_mode(input logic p, input logic s);
        @(posedge clk);
        #1;
        poll_en = p;
        slow = s;
    endtask

    task automatic send(input logic w, input logic m, input logic [12:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req = '{write: w, more: m, addr: a, data: d};
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (req_ready !== 1'b1 && n < 100);
        if (n >= 100) fail_msg("request not taken");
        @(posedge clk);
        #1;
        req_valid = 1'b0;
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        while (busy === 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic read_chk(input logic [12:0] a, input logic [7:0] exp);
        int n;
        send(1'b0, 1'b0, a, 8'h00);
        n = -1;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (rd_valid !== 1'b1 && n < 60);
        check_range(n, 17, 17, "read answer cycle");
        check_val(26'(rd_data), 26'(exp), "read data");
        wait_idle(n);
    endtask

    task automatic write_page(input logic [12:0] a, input int cnt, input logic [31:0] d,
                              input int lo, input int hi);
        int n;
        for (int i = 0; i < cnt; i++)
            send(1'b1, i < cnt - 1, a + 13'(i), d[8*i +: 8]);
        wait_idle(n);
        check_range(n, lo, hi, "busy span after last byte");
        for (int i = 0; i < cnt; i++)
            read_chk(a + 13'(i), d[8*i +: 8]);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        check_val(pins, {13'h0000, 3'b111, 8'h00, 1'b0}, "idle pins");
        check_val({24'h00_0000, busy, req_ready}, 26'h000_0001, "idle status");
    endtask

    task automatic t_read();
        read_chk(13'h0123, 8'h23 ^ 8'h5A);
        read_chk(13'h1FFF, 8'hFF ^ 8'h5A);
    endtask

    task automatic t_byte_nopoll();
        set_mode(1'b0, 1'b0);
        write_page(13'h0040, 1, 32'h0000_00A5, BLC + WC, BLC + WC + 40);
    endtask

    task automatic t_page_poll();
        set_mode(1'b1, 1'b0);
        write_page(13'h0100, 3, 32'h00C3_0281, 98, BLC + WC - 1);
    endtask

    task automatic t_page_slow();
        set_mode(1'b1, 1'b1);
        write_page(13'h1FFC, 4, 32'h3C7E_9911, 198, BLC + WC - 1);
    endtask

    // ------------------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        n_errors = 0;
        check_count = 0;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        poll_en = 1'b0;
        slow = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        t_reset();
        sys_rst = 1'b0;
        t_read();
        t_byte_nopoll();
        t_page_poll();
        t_page_slow();
        check_val(26'(viol), 26'h000_0000, "host protocol breaches");
        report_and_stop();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_msg("watchdog expired");
        report_and_stop();
    end
endmodule // eepc_host_tb
